/* verilog/spi_flash_front_end.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spi_flash_consts.svh"
module spi_flash_front_end #(
  parameter spi_flash_pkg::busyCnt_t SSE_CYC =
    spi_flash_pkg::busyCnt_t'(`CYC_OF(`T_SSE_US)),
  parameter spi_flash_pkg::busyCnt_t SE_CYC =
    spi_flash_pkg::busyCnt_t'(`CYC_OF(`T_SE_US)),
  parameter spi_flash_pkg::busyCnt_t CE_CYC =
    spi_flash_pkg::busyCnt_t'(`CYC_OF(`T_CE_US))
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             sclk,
  input  wire logic             csN,
  input  wire logic             holdN,
  input  wire logic             wpN,
  input  wire logic             dataLineZeroIn,
  input  wire logic             dataLineOneIn,
  output logic                  dataLineZeroOut,
  output logic                  dataLineZeroOeN,
  output logic                  dataLineOneOut,
  output logic                  dataLineOneOeN,
  output logic                  spiMode3,
  output logic                  rxByteValid,
  output logic            [7:0] rxByte,
  output logic                  opStart,
  output spi_flash_pkg::cmdEvt_t opEvt,
  output logic                  busy,
  output logic            [7:0] statusByte
);
  import spi_flash_pkg::*;

  localparam busyCnt_t PP_CYC = busyCnt_t'(`CYC_OF(`T_PP_US));

  pins_t       pinRaw;
  pins_t       pin;
  logic  [7:0] rdData;
  logic        memWe;
  logic  [7:0] memWrAddr;
  logic  [7:0] memWrData;

  phase_t      phase_r,    phase_nxt;
  opKind_t     op_r,       op_nxt;
  opKind_t     pend_r,     pend_nxt;
  logic [23:0] shift_r,    shift_nxt;
  logic  [4:0] bitCnt_r,   bitCnt_nxt;
  logic [23:0] addr_r,     addr_nxt;
  logic  [7:0] outShift_r, outShift_nxt;
  logic  [2:0] outCnt_r,   outCnt_nxt;
  logic  [7:0] status_r,   status_nxt;
  busyCnt_t    busyCnt_r,  busyCnt_nxt;
  logic        busy_r,     busy_nxt;
  logic        d0Out_r,    d0Out_nxt;
  logic        d1Out_r,    d1Out_nxt;
  logic        d0OeN_r,    d0OeN_nxt;
  logic        d1OeN_r,    d1OeN_nxt;
  logic        mode3_r,    mode3_nxt;
  logic        sclkPrev_r, sclkPrev_nxt;
  logic        csPrev_r,   csPrev_nxt;
  logic        wpS1_r,     wpS1_nxt;
  logic        wpS2_r,     wpS2_nxt;
  logic        rxValid_r,  rxValid_nxt;
  logic  [7:0] rxByte_r,   rxByte_nxt;
  logic        opStart_r,  opStart_nxt;
  cmdEvt_t     opEvt_r,    opEvt_nxt;

  logic csFall;
  logic csRise;
  logic active;
  logic rise;
  logic fall;
  logic [7:0] statusFull;

  // pins pass two flops before use
  assign pinRaw = '{sclk, csN, holdN, dataLineZeroIn, dataLineOneIn};

  pin_sync uSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      (pinRaw),
    .dout     (pin)
  );

  page_mem uMem (
    .core_clk (core_clk),
    .wrEn     (memWe),
    .wrAddr   (memWrAddr),
    .wrData   (memWrData),
    .rdAddr   (addr_r[7:0]),
    .rdData   (rdData)
  );

  // serial edges, gated by select and pause
  assign csFall = ~pin.csN & csPrev_r;
  assign csRise = pin.csN & ~csPrev_r;
  assign active = ~pin.csN & pin.holdN;
  assign rise   = active & pin.sclk & ~sclkPrev_r;
  assign fall   = active & ~pin.sclk & sclkPrev_r;
  assign statusFull = {status_r[7:1], busy_r};

  // next-state logic of the whole front end
  always_comb begin
    logic [7:0]  inByte;
    logic [7:0]  outB;
    logic [23:0] shN;
    logic        dualOp;
    logic        readOp;
    logic        dualIo;
    inByte = {shift_r[6:0], pin.d0};
    outB   = outShift_r;
    dualIo = (op_r == OP_DUAL_IO);
    dualOp = dualIo || (op_r == OP_DUAL_OUT);
    readOp = dualOp || (op_r == OP_READ) || (op_r == OP_FAST)
             || (op_r == OP_RDSR);
    shN = dualIo ? {shift_r[21:0], pin.d1, pin.d0}
                 : {shift_r[22:0], pin.d0};
    phase_nxt    = phase_r;
    op_nxt       = op_r;
    pend_nxt     = pend_r;
    shift_nxt    = shift_r;
    bitCnt_nxt   = bitCnt_r;
    addr_nxt     = addr_r;
    outShift_nxt = outShift_r;
    outCnt_nxt   = outCnt_r;
    status_nxt   = status_r;
    busyCnt_nxt  = busyCnt_r;
    busy_nxt     = busy_r;
    d0Out_nxt    = d0Out_r;
    d1Out_nxt    = d1Out_r;
    d0OeN_nxt    = d0OeN_r;
    d1OeN_nxt    = d1OeN_r;
    mode3_nxt    = mode3_r;
    sclkPrev_nxt = pin.sclk;
    csPrev_nxt   = pin.csN;
    wpS1_nxt     = wpN;                                 // pin, two flops
    wpS2_nxt     = wpS1_r;
    rxValid_nxt  = 1'b0;
    rxByte_nxt   = rxByte_r;
    opStart_nxt  = 1'b0;
    opEvt_nxt    = opEvt_r;
    memWe        = 1'b0;
    memWrAddr    = addr_r[7:0];
    memWrData    = inByte;

    // internal operation timer
    if (busy_r) begin
      if (busyCnt_r == `BUSY_ZERO) begin
        busy_nxt = 1'b0;
      end else begin
        busyCnt_nxt = busyCnt_r - busyCnt_t'(1);
      end
    end

    if (csFall) begin
      phase_nxt  = PH_CMD;
      mode3_nxt  = pin.sclk;
      bitCnt_nxt = 5'h00;
      outCnt_nxt = 3'h0;
      op_nxt     = OP_NONE;
      pend_nxt   = OP_NONE;
    end else if (pin.csN) begin
      // deselected: lines released, partial input dropped
      phase_nxt = PH_IDLE;
      d0OeN_nxt = 1'b1;
      d1OeN_nxt = 1'b1;
      if (csRise && pend_r != OP_NONE && !busy_r) begin
        busy_nxt    = 1'b1;
        opStart_nxt = 1'b1;
        opEvt_nxt   = '{pend_r, addr_r};
        status_nxt[`ST_WEL] = 1'b0;
        case (pend_r)
          OP_SSE:  busyCnt_nxt = SSE_CYC;
          OP_SE:   busyCnt_nxt = SE_CYC;
          OP_CE:   busyCnt_nxt = CE_CYC;
          default: busyCnt_nxt = PP_CYC;
        endcase
      end
      pend_nxt = OP_NONE;
    end else if (rise) begin
      case (phase_r)
        PH_CMD: begin
          shift_nxt  = {shift_r[22:0], pin.d0};
          bitCnt_nxt = bitCnt_r + 5'h01;
          if (bitCnt_r == `BYTE_LAST) begin
            bitCnt_nxt  = 5'h00;
            rxValid_nxt = 1'b1;
            rxByte_nxt  = inByte;
            phase_nxt   = PH_SKIP;
            if (!busy_r || inByte == `CMD_RDSR) begin
              case (inByte)
                `CMD_READ: begin
                  op_nxt = OP_READ;
                  phase_nxt = PH_ADDR;
                end
                `CMD_FAST: begin
                  op_nxt = OP_FAST;
                  phase_nxt = PH_ADDR;
                end
                `CMD_DUAL_OUT: begin
                  op_nxt = OP_DUAL_OUT;
                  phase_nxt = PH_ADDR;
                end
                `CMD_DUAL_IO: begin
                  op_nxt = OP_DUAL_IO;
                  phase_nxt = PH_ADDR;
                end
                `CMD_PP, `CMD_SSE_A, `CMD_SSE_B, `CMD_SE: begin
                  op_nxt = (inByte == `CMD_PP) ? OP_PROG :
                           (inByte == `CMD_SE) ? OP_SE : OP_SSE;
                  if (status_r[`ST_WEL]) begin
                    phase_nxt = PH_ADDR;
                  end
                end
                `CMD_CE_A, `CMD_CE_B: begin
                  if (status_r[`ST_WEL]) begin
                    pend_nxt = OP_CE;
                    addr_nxt = '0;
                  end
                end
                `CMD_WREN: status_nxt[`ST_WEL] = 1'b1;
                `CMD_WRDI: status_nxt[`ST_WEL] = 1'b0;
                `CMD_RDSR: begin
                  op_nxt = OP_RDSR;
                  phase_nxt = PH_DATA;
                end
                `CMD_WRSR: begin
                  op_nxt = OP_WRSR;
                  phase_nxt = PH_DATA;
                end
                default: phase_nxt = PH_SKIP;
              endcase
            end
          end
        end
        PH_ADDR: begin
          shift_nxt  = shN;
          bitCnt_nxt = bitCnt_r + 5'h01;
          if (bitCnt_r == (dualIo ? `DUAL_ADDR_LAST : `ADDR_LAST)) begin
            bitCnt_nxt = 5'h00;
            addr_nxt   = shN & `ADDR_MASK;
            case (op_r)
              OP_READ, OP_PROG: phase_nxt = PH_DATA;
              OP_SSE, OP_SE: begin
                pend_nxt  = op_r;
                phase_nxt = PH_SKIP;
              end
              default: phase_nxt = PH_DUMMY;
            endcase
          end
        end
        PH_DUMMY: begin
          bitCnt_nxt = bitCnt_r + 5'h01;
          if (bitCnt_r == (dualIo ? `DUAL_DUMMY_LAST : `DUMMY_LAST)) begin
            bitCnt_nxt = 5'h00;
            phase_nxt  = PH_DATA;
          end
        end
        PH_DATA: begin
          if (!readOp) begin
            shift_nxt  = {shift_r[22:0], pin.d0};
            bitCnt_nxt = bitCnt_r + 5'h01;
            if (bitCnt_r == `BYTE_LAST) begin
              bitCnt_nxt  = 5'h00;
              rxValid_nxt = 1'b1;
              rxByte_nxt  = inByte;
              if (op_r == OP_PROG) begin
                memWe    = 1'b1;
                pend_nxt = OP_PROG;
                // address wraps inside the page
                addr_nxt[7:0] = addr_r[7:0] + `PAGE_ONE;
              end else begin
                phase_nxt = PH_SKIP;
                if (!(status_r[`ST_LOCK] && !wpS2_r)) begin
                  status_nxt[`ST_LOCK] = inByte[`ST_LOCK];
                  status_nxt[`ST_BP_HI:`ST_BP_LO] =
                    inByte[`ST_BP_HI:`ST_BP_LO];
                end
                status_nxt[`ST_WEL] = 1'b0;
              end
            end
          end
        end
        default: ;
      endcase
    end else if (fall && phase_r == PH_DATA && readOp) begin
      // load a new byte or shift the current one out
      if (outCnt_r == 3'h0) begin
        outB = (op_r == OP_RDSR) ? statusFull : rdData;
        if (op_r != OP_RDSR) begin
          addr_nxt = (addr_r + `ADDR_ONE) & `ADDR_MASK;
        end
      end
      if (dualOp) begin
        d0Out_nxt    = outB[7];
        d1Out_nxt    = outB[6];
        d0OeN_nxt    = 1'b0;
        d1OeN_nxt    = 1'b0;
        outShift_nxt = {outB[5:0], 2'b00};
        outCnt_nxt   = (outCnt_r == `DUAL_OUT_LAST) ? 3'h0
                                                    : outCnt_r + 3'h1;
      end else begin
        d1Out_nxt    = outB[7];
        d1OeN_nxt    = 1'b0;
        outShift_nxt = {outB[6:0], 1'b0};
        outCnt_nxt   = (outCnt_r == `SGL_OUT_LAST) ? 3'h0
                                                   : outCnt_r + 3'h1;
      end
    end
  end

  // state registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase_r    <= PH_IDLE;
      op_r       <= OP_NONE;
      pend_r     <= OP_NONE;
      shift_r    <= '0;
      bitCnt_r   <= 5'h00;
      addr_r     <= '0;
      outShift_r <= 8'h00;
      outCnt_r   <= 3'h0;
      status_r   <= `STATUS_RST;
      busyCnt_r  <= `BUSY_ZERO;
      busy_r     <= 1'b0;
      d0Out_r    <= 1'b0;
      d1Out_r    <= 1'b0;
      d0OeN_r    <= 1'b1;
      d1OeN_r    <= 1'b1;
      mode3_r    <= 1'b0;
      sclkPrev_r <= 1'b0;
      csPrev_r   <= 1'b1;
      wpS1_r     <= 1'b1;
      wpS2_r     <= 1'b1;
      rxValid_r  <= 1'b0;
      rxByte_r   <= 8'h00;
      opStart_r  <= 1'b0;
      opEvt_r    <= '0;
    end else begin
      phase_r    <= phase_nxt;
      op_r       <= op_nxt;
      pend_r     <= pend_nxt;
      shift_r    <= shift_nxt;
      bitCnt_r   <= bitCnt_nxt;
      addr_r     <= addr_nxt;
      outShift_r <= outShift_nxt;
      outCnt_r   <= outCnt_nxt;
      status_r   <= status_nxt;
      busyCnt_r  <= busyCnt_nxt;
      busy_r     <= busy_nxt;
      d0Out_r    <= d0Out_nxt;
      d1Out_r    <= d1Out_nxt;
      d0OeN_r    <= d0OeN_nxt;
      d1OeN_r    <= d1OeN_nxt;
      mode3_r    <= mode3_nxt;
      sclkPrev_r <= sclkPrev_nxt;
      csPrev_r   <= csPrev_nxt;
      wpS1_r     <= wpS1_nxt;
      wpS2_r     <= wpS2_nxt;
      rxValid_r  <= rxValid_nxt;
      rxByte_r   <= rxByte_nxt;
      opStart_r  <= opStart_nxt;
      opEvt_r    <= opEvt_nxt;
    end
  end

  // outputs straight from registers
  assign dataLineZeroOut = d0Out_r;
  assign dataLineZeroOeN = d0OeN_r;
  assign dataLineOneOut  = d1Out_r;
  assign dataLineOneOeN  = d1OeN_r;
  assign spiMode3        = mode3_r;
  assign rxByteValid     = rxValid_r;
  assign rxByte          = rxByte_r;
  assign opStart         = opStart_r;
  assign opEvt           = opEvt_r;
  assign busy            = busy_r;
  assign statusByte      = statusFull;
endmodule
`default_nettype wire

/* inc/spi_flash_consts.svh */
`ifndef SPI_FLASH_CONSTS_SVH
`define SPI_FLASH_CONSTS_SVH

// command bytes
`define CMD_READ      8'h03
`define CMD_FAST      8'h0b
`define CMD_DUAL_OUT  8'h3b
`define CMD_DUAL_IO   8'hbb
`define CMD_SSE_A     8'h20
`define CMD_SSE_B     8'hd7
`define CMD_SE        8'hd8
`define CMD_CE_A      8'h60
`define CMD_CE_B      8'hc7
`define CMD_PP        8'h02
`define CMD_WREN      8'h06
`define CMD_WRDI      8'h04
`define CMD_RDSR      8'h05
`define CMD_WRSR      8'h01

// status byte layout
`define ST_BUSY       0
`define ST_WEL        1
`define ST_BP_LO      2
`define ST_BP_HI      4
`define ST_LOCK       7
`define STATUS_RST    8'h00

// bit counts per phase (last index), address mask and steps, pin reset value
`define BYTE_LAST     5'h07
`define ADDR_LAST     5'h17
`define DUAL_ADDR_LAST 5'h0b
`define DUMMY_LAST    5'h07
`define DUAL_DUMMY_LAST 5'h03
`define SGL_OUT_LAST  3'h7
`define DUAL_OUT_LAST 3'h3
`define ADDR_MASK     24'h0fffff
`define ADDR_ONE      24'h000001
`define PAGE_ONE      8'h01
`define PINS_RST      5'h0c

// operation times in microseconds and their cycle counts
`define CLK_MHZ       10
`define T_SSE_US      40000
`define T_SE_US       80000
`define T_CE_US       500000
`define T_PP_US       300
`define CYC_OF(us)    ((us) * `CLK_MHZ)
`define BUSY_W        26
`define BUSY_ZERO     26'h0000000

`endif

/* inc/spi_flash_pkg.sv */
`include "spi_flash_consts.svh"
package spi_flash_pkg;

  // command phase, gray coded along idle-cmd-addr-dummy-data
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_CMD   = 3'b001,
    PH_ADDR  = 3'b011,
    PH_DUMMY = 3'b010,
    PH_DATA  = 3'b110,
    PH_SKIP  = 3'b111
  } phase_t;

  typedef enum logic [3:0] {
    OP_NONE, OP_READ, OP_FAST, OP_DUAL_OUT, OP_DUAL_IO, OP_PROG,
    OP_SSE, OP_SE, OP_CE, OP_WRSR, OP_RDSR
  } opKind_t;

  typedef logic [`BUSY_W-1:0] busyCnt_t;

  // started internal operation
  typedef struct packed {
    opKind_t     kind;
    logic [23:0] addr;
  } cmdEvt_t;

  // serial pins as sampled
  typedef struct packed {
    logic sclk;
    logic csN;
    logic holdN;
    logic d0;
    logic d1;
  } pins_t;

endpackage

/* verilog/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spi_flash_consts.svh"
module pin_sync (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire spi_flash_pkg::pins_t din,
  output spi_flash_pkg::pins_t     dout
);
  import spi_flash_pkg::*;

  localparam int W = $bits(pins_t);
  localparam logic [W-1:0] RSTV = `PINS_RST;
  logic [W-1:0] q;

  // two flops per pin
  for (genvar i = 0; i < W; i++) begin : gBit
    logic s1_r;
    logic s2_r;
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        s1_r <= RSTV[i];
        s2_r <= RSTV[i];
      end else begin
        s1_r <= din[i];
        s2_r <= s1_r;
      end
    end
    assign q[i] = s2_r;
  end

  assign dout = pins_t'(q);
endmodule
`default_nettype wire

/* verilog/page_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module page_mem (
  input  wire logic       core_clk,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrAddr,
  input  wire logic [7:0] wrData,
  input  wire logic [7:0] rdAddr,
  output logic      [7:0] rdData
);
  logic [7:0] mem [256];

  // one write port, registered read
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

/* tb/spi_flash_front_end_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spi_flash_consts.svh"
module spi_flash_front_end_monitor #(
  parameter spi_flash_pkg::busyCnt_t SSE_CYC = 26'h0000014,
  parameter spi_flash_pkg::busyCnt_t SE_CYC  = 26'h000001e,
  parameter spi_flash_pkg::busyCnt_t CE_CYC  = 26'h0000028
) (
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  input wire logic                   sclk,
  input wire logic                   csN,
  input wire logic                   holdN,
  input wire logic                   wpN,
  input wire logic                   dataLineZeroIn,
  input wire logic                   dataLineOneIn,
  input wire logic                   dataLineZeroOut,
  input wire logic                   dataLineZeroOeN,
  input wire logic                   dataLineOneOut,
  input wire logic                   dataLineOneOeN,
  input wire logic                   spiMode3,
  input wire logic                   rxByteValid,
  input wire logic             [7:0] rxByte,
  input wire logic                   opStart,
  input wire spi_flash_pkg::cmdEvt_t opEvt,
  input wire logic                   busy,
  input wire logic             [7:0] statusByte
);
  import spi_flash_pkg::*;
  busyCnt_t lenCnt_r;
  busyCnt_t lenCnt_nxt;
  busyCnt_t expLen;
  // length of the running operation and its expected figure
  always_comb begin
    lenCnt_nxt = busy ? lenCnt_r + 1'h1 : '0;
    case (opEvt.kind)
      OP_PROG: expLen = busyCnt_t'(`CYC_OF(`T_PP_US));
      OP_SSE:  expLen = SSE_CYC;
      OP_SE:   expLen = SE_CYC;
      OP_CE:   expLen = CE_CYC;
      default: expLen = lenCnt_r;
    endcase
  end
  always_ff @(posedge core_clk) begin
    lenCnt_r <= rst_n ? lenCnt_nxt : '0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_DESEL_IDLE: assert property (
    csN [*6] |-> dataLineZeroOeN && dataLineOneOeN)
    else $error("data line driven while deselected");
  AST_OUT_ON_FALL: assert property (
    !csN && $past(!csN) && $changed(dataLineOneOut) |-> !sclk)
    else $error("output changed while serial clock high");
  AST_RX_ON_RISE: assert property (
    rxByteValid |-> $past(sclk, 2) && !$past(csN, 2))
    else $error("byte taken away from a clock rise");
  AST_MODE_PICK: assert property (
    $fell(csN) |-> ##5 (spiMode3 == sclk))
    else $error("mode does not follow idle clock level");
  AST_HOLD_FREEZE: assert property (
    !holdN [*4] |-> $stable(dataLineOneOut) && !rxByteValid)
    else $error("transfer moved during pause");
  AST_OP_BUSY: assert property (
    opStart |=> busy && statusByte[0])
    else $error("busy not shown after start");
  AST_BUSY_LEN: assert property (
    $fell(busy) |-> lenCnt_r + 2 >= expLen && lenCnt_r <= expLen + 2)
    else $error("operation length wrong");
  AST_DUAL_PAIR: assert property (
    !dataLineZeroOeN |-> !dataLineOneOeN)
    else $error("line zero driven alone");
  AST_START_KIND: assert property (
    opStart |-> csN && opEvt.kind inside {OP_PROG, OP_SSE, OP_SE, OP_CE})
    else $error("bad operation start");
  AST_LOCK_HOLD: assert property (
    !wpN && $stable(wpN) && statusByte[7] |=> $stable(statusByte[7:2]))
    else $error("locked status changed");
  cover property (opStart && opEvt.kind == OP_PROG);
  cover property (!dataLineZeroOeN);
  cover property ($fell(csN) ##5 spiMode3);
endmodule
`default_nettype wire

/* tb/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic core_clk,
  input  wire logic d0Wire,
  input  wire logic d1Wire,
  output logic      sclk,
  output logic      csN,
  output logic      holdN,
  output logic      d0Out,
  output logic      d0OeN,
  output logic      d1Out,
  output logic      d1OeN
);
  initial begin
    sclk = 1'h0;
    csN = 1'h1;
    holdN = 1'h1;
    d0Out = 1'h0;
    d0OeN = 1'h1;
    d1Out = 1'h0;
    d1OeN = 1'h1;
  end
  // half serial period, 800 ns clock far below the top rate
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask
  // select with the idle level of the clock
  task automatic sel(input logic m3);
    sclk = m3;
    half();
    csN = 1'h0;
    half();
    half();
    d0OeN = 1'h0;
  endtask
  task automatic desel(input logic m3);
    sclk = m3;
    half();
    csN = 1'h1;
    d0OeN = 1'h1;
    half();
    half();
  endtask
  task automatic hold(input logic v);
    holdN = v;
    half();
  endtask
  // n bits msb first, one per rise
  task automatic bits(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      sclk = 1'h0;
      d0Out = v[i];
      half();
      sclk = 1'h1;
      half();
    end
  endtask
  // two bits per rise, line one carries the higher bit
  task automatic bits2(input logic [7:0] v);
    d1OeN = 1'h0;
    for (int i = 7; i > 0; i -= 2) begin
      sclk = 1'h0;
      d1Out = v[i];
      d0Out = v[i-1];
      half();
      sclk = 1'h1;
      half();
    end
  endtask
  // one byte in, host lets go of line zero in two-line mode
  task automatic rd(input logic dual, output logic [7:0] v);
    v = 8'h00;
    d0OeN = dual;
    d1OeN = 1'h1;
    for (int i = 0; i < (dual ? 4 : 8); i++) begin
      sclk = 1'h0;
      half();
      sclk = 1'h1;
      v = dual ? {v[5:0], d0Wire, d1Wire} : {v[6:0], d1Wire};
      half();
    end
  endtask
endmodule
`default_nettype wire

/* tb/spi_flash_front_end_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_flash_front_end_tb;
  import spi_flash_pkg::*;
  logic       core_clk, rst_n, wpN, flt, sclk, csN, holdN, d0Out, d0OeN;
  logic       zOut, zOeN, oOut, oOeN, spiMode3, rxValid, opStart, busy;
  logic [7:0] rxByte, statusByte, b;
  logic       d1Out, d1OeN;
  cmdEvt_t    opEvt;
  int         error_cnt, checks_done, opCnt;
  logic [7:0] eCmd [5] = '{8'h20, 8'hd7, 8'hd8, 8'h60, 8'hc7};
  opKind_t    eKind [5] = '{OP_SSE, OP_SSE, OP_SE, OP_CE, OP_CE};
  wire        d0Wire = !zOeN ? zOut : (d0OeN ? flt : d0Out);
  wire        d1Wire = !oOeN ? oOut : (d1OeN ? flt : d1Out);
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) flt <= ~flt;
  always @(negedge core_clk) if (opStart === 1'h1) opCnt++;
  spi_flash_front_end #(.SSE_CYC(26'h14), .SE_CYC(26'h1e), .CE_CYC(26'h28))
  spi_flash_front_end_inst (
    .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .csN(csN),
    .holdN(holdN), .wpN(wpN), .dataLineZeroIn(d0Wire),
    .dataLineOneIn(d1Wire), .dataLineZeroOut(zOut),
    .dataLineZeroOeN(zOeN), .dataLineOneOut(oOut), .dataLineOneOeN(oOeN),
    .spiMode3(spiMode3), .rxByteValid(rxValid), .rxByte(rxByte),
    .opStart(opStart), .opEvt(opEvt), .busy(busy),
    .statusByte(statusByte));
  spi_host_model spi_host_model_inst (
    .core_clk(core_clk), .d0Wire(d0Wire), .d1Wire(d1Wire), .sclk(sclk),
    .csN(csN), .holdN(holdN), .d0Out(d0Out), .d0OeN(d0OeN),
    .d1Out(d1Out), .d1OeN(d1OeN));
  task automatic chk(input string nm, input logic [31:0] e, got);
    checks_done++;
    if (got !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic send(input logic m3, input logic [7:0] c);
    spi_host_model_inst.sel(m3);
    spi_host_model_inst.bits(c, 8);
  endtask
  task automatic adr(input logic [23:0] a);
    spi_host_model_inst.bits(a[23:16], 8);
    spi_host_model_inst.bits(a[15:8], 8);
    spi_host_model_inst.bits(a[7:0], 8);
  endtask
  // deselect, then wait a bounded time for the operation to end
  task automatic fin(input logic m3);
    spi_host_model_inst.desel(m3);
    for (int i = 0; i < 4000 && busy !== 1'h0; i++) @(negedge core_clk);
    chk("busy", 0, busy);
  endtask
  task automatic get(input logic dual, input logic [7:0] e);
    spi_host_model_inst.rd(dual, b);
    chk("rdata", e, b);
  endtask
  task automatic wrsr(input logic [7:0] v);
    send(0, 8'h06);
    fin(0);
    send(0, 8'h01);
    spi_host_model_inst.bits(v, 8);
    fin(0);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    results();
  end
  initial begin
    core_clk = 1'h0;
    rst_n = 1'h0;
    wpN = 1'h1;
    flt = 1'h0;
    repeat (20) @(negedge core_clk);
    chk("oen", 1, zOeN & oOeN);
    chk("status", 8'h00, statusByte);
    rst_n = 1'h1;
    spi_host_model_inst.sel(0);
    spi_host_model_inst.bits(8'h06, 4);
    fin(0);
    chk("status", 8'h00, statusByte);
    send(0, 8'h06);
    chk("rxbyte", 8'h06, rxByte);
    fin(0);
    send(1, 8'h05);
    get(0, 8'h02);
    chk("mode3", 1, spiMode3);
    fin(1);
    send(0, 8'h02);
    adr(24'hf23405);
    spi_host_model_inst.bits(8'ha5, 8);
    spi_host_model_inst.bits(8'h3c, 8);
    fin(0);
    chk("opcnt", 1, opCnt);
    chk("opkind", OP_PROG, opEvt.kind);
    // event address has moved past the two page bytes
    chk("opaddr", 24'h023407, opEvt.addr);
    // read in mode 3 with a pause inside the address
    send(1, 8'h03);
    spi_host_model_inst.bits(8'hf0, 8);
    spi_host_model_inst.hold(0);
    spi_host_model_inst.bits(8'hff, 8);
    spi_host_model_inst.hold(1);
    spi_host_model_inst.bits(8'h00, 8);
    spi_host_model_inst.bits(8'h05, 8);
    get(0, 8'ha5);
    get(0, 8'h3c);
    fin(1);
    send(0, 8'h0b);
    adr(24'h000006);
    spi_host_model_inst.bits(8'h00, 8);
    get(0, 8'h3c);
    fin(0);
    send(0, 8'h3b);
    adr(24'h000005);
    spi_host_model_inst.bits(8'h00, 8);
    get(1, 8'ha5);
    chk("dual oen", 0, zOeN | oOeN);
    get(1, 8'h3c);
    fin(0);
    // two-line io: address on both lines, 4 dummy clocks
    send(0, 8'hbb);
    spi_host_model_inst.bits2(8'h00);
    spi_host_model_inst.bits2(8'h00);
    spi_host_model_inst.bits2(8'h05);
    spi_host_model_inst.bits2(8'h00);
    get(1, 8'ha5);
    chk("dual io oen", 0, zOeN | oOeN);
    fin(0);
    wrsr(8'h9c);
    chk("status", 8'h9c, statusByte);
    wpN = 1'h0;
    wrsr(8'h00);
    chk("status", 8'h9c, statusByte);
    wpN = 1'h1;
    wrsr(8'h00);
    chk("status", 8'h00, statusByte);
    send(0, 8'h06);
    fin(0);
    chk("status", 8'h02, statusByte);
    send(0, 8'h04);
    fin(0);
    chk("status", 8'h00, statusByte);
    send(0, 8'h20);
    adr(24'h001000);
    fin(0);
    chk("opcnt", 1, opCnt);
    for (int i = 0; i < 5; i++) begin
      send(0, 8'h06);
      fin(0);
      send(0, eCmd[i]);
      if (i < 3) adr(24'h010000);
      fin(0);
      chk("opcnt", i + 2, opCnt);
      chk("opkind", eKind[i], opEvt.kind);
    end
    results();
  end
endmodule
bind spi_flash_front_end spi_flash_front_end_monitor
  spi_flash_front_end_monitor_inst (
  .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .csN(csN),
  .holdN(holdN), .wpN(wpN), .dataLineZeroIn(dataLineZeroIn),
  .dataLineOneIn(dataLineOneIn), .dataLineZeroOut(dataLineZeroOut),
  .dataLineZeroOeN(dataLineZeroOeN), .dataLineOneOut(dataLineOneOut),
  .dataLineOneOeN(dataLineOneOeN), .spiMode3(spiMode3),
  .rxByteValid(rxByteValid), .rxByte(rxByte), .opStart(opStart),
  .opEvt(opEvt), .busy(busy), .statusByte(statusByte));
`default_nettype wire
